//--- sim/test_can_interrupt_mask_control.sv
// Self-checking bench for the interrupt mask register block
`timescale 1ns/1ps
`default_nettype none
module test_can_interrupt_mask_control;
    logic        clk;
    logic        rst_b;
    logic        clk_en;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] flags;
    logic [31:0] rdata;
    logic [31:0] mask;
    logic        irq;
    logic [31:0] exp_m;
    logic [31:0] got;
    int          n_errors;
    int          tests_run;

    can_interrupt_mask_control u_dut (
        .core_clk_in(clk),
        .rst_b_in   (rst_b),
        .clk_en_in  (clk_en),
        .addr_in    (addr),
        .wdata_in   (wdata),
        .wr_in      (wr),
        .rd_in      (rd),
        .flags_in   (flags),
        .rdata_out  (rdata),
        .mask_out   (mask),
        .irq_out    (irq)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk32(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic bus_rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic chk_mask();
        bus_rd(irq_mask_pkg::OFS_MASK, got);
        chk32("mask reg", exp_m, got);
        chk32("mask port", exp_m, mask);
    endtask

    task automatic end_sim();
        $display("Checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic t_enable();
        chk_mask();
        for (int i = 24; i <= 28; i++) begin
            bus_wr(irq_mask_pkg::OFS_ENABLE, 32'h0000_0001 << i);
            exp_m[i] = 1'b1;
            chk_mask();
        end
        bus_wr(irq_mask_pkg::OFS_ENABLE, 32'h0000_0000);
        chk_mask();
        $display("enable test done");
    endtask

    task automatic t_disable();
        bus_wr(irq_mask_pkg::OFS_ENABLE, 32'hFFFF_FFFF);
        exp_m = irq_mask_pkg::VALID_BITS;
        chk_mask();
        bus_wr(irq_mask_pkg::OFS_DISABLE, 32'h0000_0000);
        chk_mask();
        for (int i = 0; i < 32; i++) begin
            if (irq_mask_pkg::VALID_BITS[i]) begin
                bus_wr(irq_mask_pkg::OFS_DISABLE, 32'h0000_0001 << i);
                exp_m[i] = 1'b0;
                chk_mask();
                chk_mask();
            end
        end
        $display("disable test done");
    endtask

    task automatic t_irq();
        // Flag on a masked-off source must stay silent
        flags <= 32'h0200_0000;
        bus_wr(irq_mask_pkg::OFS_ENABLE, 32'h0100_0000);
        repeat (3) @(posedge clk);
        #1 chk32("irq off", 32'(0), 32'(irq));
        flags <= 32'h0300_0000;
        repeat (3) @(posedge clk);
        #1 chk32("irq on", 32'(1), 32'(irq));
        bus_wr(irq_mask_pkg::OFS_DISABLE, 32'h0100_0000);
        repeat (3) @(posedge clk);
        #1 chk32("irq cleared", 32'(0), 32'(irq));
        exp_m = 32'h0000_0000;
        $display("irq test done");
    endtask

    task automatic t_unmapped();
        bus_wr(12'h0FC, 32'hFFFF_FFFF);
        chk_mask();
        bus_rd(irq_mask_pkg::OFS_DISABLE, got);
        chk32("disable read", 32'h0000_0000, got);
        bus_rd(12'h0FC, got);
        chk32("unmapped read", 32'h0000_0000, got);
        $display("unmapped test done");
    endtask

    // Pending word read back, then read data fall to idle
    task automatic t_status();
        flags <= 32'h0000_0011;
        bus_wr(irq_mask_pkg::OFS_ENABLE, 32'h0000_0001);
        exp_m = 32'h0000_0001;
        chk_mask();
        bus_rd(irq_mask_pkg::OFS_STATUS, got);
        chk32("pending read", 32'h0000_0001, got);
        @(posedge clk);
        #1 chk32("read idle", 32'h0000_0000, rdata);
        bus_wr(irq_mask_pkg::OFS_DISABLE, 32'h0000_0001);
        flags <= 32'h0000_0000;
        exp_m = 32'h0000_0000;
        chk_mask();
        $display("status test done");
    endtask

    // A write while the clock enable is low must not land
    task automatic t_freeze();
        @(posedge clk);
        clk_en <= 1'b0;
        bus_wr(irq_mask_pkg::OFS_ENABLE, 32'h1000_0000);
        repeat (2) @(posedge clk);
        #1 chk32("frozen mask port", exp_m, mask);
        @(posedge clk);
        clk_en <= 1'b1;
        chk_mask();
        $display("freeze test done");
    endtask

    initial begin
        n_errors  = 0;
        tests_run = 0;
        rst_b     = 1'b0;
        clk_en    = 1'b1;
        addr      = 12'h000;
        wdata     = 32'h0000_0000;
        wr        = 1'b0;
        rd        = 1'b0;
        flags     = 32'h0000_0000;
        exp_m     = 32'h0000_0000;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        t_enable();
        t_disable();
        t_irq();
        t_unmapped();
        t_status();
        t_freeze();
        end_sim();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_sim();
    end
endmodule
`default_nettype wire

//--- src/can_interrupt_mask_control.sv
// Interrupt enable, disable and mask registers of the CAN controller
`timescale 1ns/1ps
`default_nettype none
module can_interrupt_mask_control (
    input  wire logic        core_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        clk_en_in,
    input  wire logic [11:0] addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    input  wire logic [31:0] flags_in,
    output var  logic [31:0] rdata_out,
    output var  logic [31:0] mask_out,
    output var  logic        irq_out
);
    logic        wr_enable;
    logic        wr_disable;
    logic        rd_mask;
    logic        rd_status;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic [31:0] mask_vec;
    logic [31:0] pend_vec;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    assign wr_enable  = wr_in && (addr_in == irq_mask_pkg::OFS_ENABLE);
    assign wr_disable = wr_in && (addr_in == irq_mask_pkg::OFS_DISABLE);
    assign rd_mask    = rd_in && (addr_in == irq_mask_pkg::OFS_MASK);
    assign rd_status  = rd_in && (addr_in == irq_mask_pkg::OFS_STATUS);

    // Write-one set and clear of any number of valid bits; zero bits leave the mask alone
    assign set_vec = wr_enable ? (wdata_in & irq_mask_pkg::VALID_BITS)
                               : 32'h0000_0000;
    assign clr_vec = wr_disable ? (wdata_in & irq_mask_pkg::VALID_BITS)
                                : 32'h0000_0000;

    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_bit
            if (irq_mask_pkg::VALID_BITS[g]) begin : g_cell
                mask_bit_cell u_cell (
                    .core_clk_in (core_clk_in),
                    .rst_b_in    (rst_b_in),
                    .clk_en_in   (clk_en_in),
                    .set_in      (set_vec[g]),
                    .clr_in      (clr_vec[g]),
                    .mask_out    (mask_vec[g])
                );
            end else begin : g_rsvd
                // Reserved positions hold no state and read zero
                assign mask_vec[g] = 1'b0;
            end
        end
    endgenerate

    irq_gate u_gate (
        .core_clk_in (core_clk_in),
        .rst_b_in    (rst_b_in),
        .clk_en_in   (clk_en_in),
        .flags_in    (flags_in),
        .mask_in     (mask_vec),
        .pend_out    (pend_vec),
        .irq_out     (irq_out)
    );

    // Write-only and unmapped addresses read zero
    assign rdata_d = rd_mask   ? mask_vec :
                     rd_status ? pend_vec :
                                 irq_mask_pkg::READ_IDLE;

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            rdata_q  <= irq_mask_pkg::READ_IDLE;
            mask_out <= irq_mask_pkg::MASK_RESET;
        end else if (clk_en_in) begin
            rdata_q  <= rdata_d;
            mask_out <= mask_vec;
        end
    end
    assign rdata_out = rdata_q;

    // Strobes are single cycles, so each step is one sampled cycle
    sequence s_en_write(int b);
        clk_en_in && wr_enable && wdata_in[b];
    endsequence

    sequence s_dis_write(int b);
        clk_en_in && wr_disable && wdata_in[b];
    endsequence

    // No write of any kind carries this bit
    sequence s_untouched(int b);
        clk_en_in && !(wr_in && wdata_in[b]);
    endsequence

    property p_sets(int b);
        @(posedge core_clk_in) disable iff (!rst_b_in)
        s_en_write(b) |=> mask_vec[b];
    endproperty

    property p_clears(int b);
        @(posedge core_clk_in) disable iff (!rst_b_in)
        s_dis_write(b) |=> !mask_vec[b];
    endproperty

    property p_keeps(int b);
        @(posedge core_clk_in) disable iff (!rst_b_in)
        s_untouched(b) |=> mask_vec[b] == $past(mask_vec[b]);
    endproperty

    sequence s_set_then_read(int b);
        s_en_write(b) ##1 (clk_en_in && !wr_disable)
        ##1 (clk_en_in && rd_mask);
    endsequence

    sequence s_clear_then_read(int b);
        s_dis_write(b) ##1 (clk_en_in && !wr_enable)
        ##1 (clk_en_in && rd_mask);
    endsequence

    // Enable side: one check per fault source
    chk_crc_enable: assert property (
        p_sets(irq_mask_pkg::POS_CRC))
        else $error("CRC fault mask not set");

    chk_stuff_enable: assert property (
        p_sets(irq_mask_pkg::POS_STUFF))
        else $error("Stuffing fault mask not set");

    chk_ack_enable: assert property (
        p_sets(irq_mask_pkg::POS_ACK))
        else $error("Ack fault mask not set");

    chk_form_enable: assert property (
        p_sets(irq_mask_pkg::POS_FORM))
        else $error("Form fault mask not set");

    chk_bit_enable: assert property (
        p_sets(irq_mask_pkg::POS_BIT))
        else $error("Bit fault mask not set");

    // A zero bit must not move the mask
    chk_zero_keeps: assert property (
        p_keeps(irq_mask_pkg::POS_ACK))
        else $error("Ack fault mask moved without cause");

    chk_stuff_keeps: assert property (
        p_keeps(irq_mask_pkg::POS_STUFF))
        else $error("Stuffing fault mask moved without cause");

    chk_form_keeps: assert property (
        p_keeps(irq_mask_pkg::POS_FORM))
        else $error("Form fault mask moved without cause");

    chk_bit_keeps: assert property (
        p_keeps(irq_mask_pkg::POS_BIT))
        else $error("Bit fault mask moved without cause");

    chk_crc_keeps: assert property (
        p_keeps(irq_mask_pkg::POS_CRC))
        else $error("CRC fault mask moved without cause");

    // Mailbox disables repeat per entry
    genvar m;
    generate
        for (m = 0; m < irq_mask_pkg::NUM_MSGBOX; m++) begin : g_mbox_chk
            chk_mbox_disable: assert property (
                p_clears(irq_mask_pkg::POS_MSGBOX + m))
                else $error("Mailbox mask not cleared");
        end
    endgenerate

    // Disable side: one check per state, event and fault source
    chk_active_disable: assert property (
        p_clears(irq_mask_pkg::POS_ACTIVE))
        else $error("Fault active mask not cleared");

    chk_warn_disable: assert property (
        p_clears(irq_mask_pkg::POS_WARN))
        else $error("Warning limit mask not cleared");

    chk_passive_disable: assert property (
        p_clears(irq_mask_pkg::POS_PASSIVE))
        else $error("Fault passive mask not cleared");

    chk_busoff_disable: assert property (
        p_clears(irq_mask_pkg::POS_BUSOFF))
        else $error("Bus off mask not cleared");

    chk_sleep_disable: assert property (
        p_clears(irq_mask_pkg::POS_SLEEP))
        else $error("Sleep mask not cleared");

    chk_wakeup_disable: assert property (
        p_clears(irq_mask_pkg::POS_WAKEUP))
        else $error("Wakeup mask not cleared");

    chk_overflow_disable: assert property (
        p_clears(irq_mask_pkg::POS_TIMER_OVF))
        else $error("Timer overflow mask not cleared");

    chk_tstamp_disable: assert property (
        p_clears(irq_mask_pkg::POS_TSTAMP))
        else $error("Timestamp event mask not cleared");

    chk_crc_disable: assert property (
        p_clears(irq_mask_pkg::POS_CRC))
        else $error("CRC fault mask not cleared");

    chk_stuff_disable: assert property (
        p_clears(irq_mask_pkg::POS_STUFF))
        else $error("Stuffing fault mask not cleared");

    chk_ack_disable: assert property (
        p_clears(irq_mask_pkg::POS_ACK))
        else $error("Ack fault mask not cleared");

    chk_form_disable: assert property (
        p_clears(irq_mask_pkg::POS_FORM))
        else $error("Form fault mask not cleared");

    chk_bit_disable: assert property (
        p_clears(irq_mask_pkg::POS_BIT))
        else $error("Bit fault mask not cleared");

    // Every implemented bit: set, clear and hold behave alike
    genvar v;
    generate
        for (v = 0; v < 32; v++) begin : g_bit_chk
            if (irq_mask_pkg::VALID_BITS[v]) begin : g_live
                chk_any_set: assert property (
                    p_sets(v))
                    else $error("Mask bit not set by enable");
                chk_any_clear: assert property (
                    p_clears(v))
                    else $error("Mask bit not cleared by disable");
                chk_any_keep: assert property (
                    p_keeps(v))
                    else $error("Mask bit moved without a write");
            end else begin : g_dead
                chk_dead_zero: assert property (
                    @(posedge core_clk_in) disable iff (!rst_b_in)
                    !mask_vec[v])
                    else $error("Reserved mask bit holds state");
            end
        end
    endgenerate

    // Every other bit survives a write; reserved bits never hold state
    chk_others_kept: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        clk_en_in && wr_in |=> ((mask_vec ^ $past(mask_vec))
        & ~$past(wdata_in)) == 32'h0000_0000)
        else $error("Mask bit moved outside the written ones");

    chk_unmapped_write: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        clk_en_in && wr_in && !wr_enable && !wr_disable
        |=> mask_vec == $past(mask_vec))
        else $error("Mask moved on a foreign write");

    chk_rsvd_zero: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        (mask_out & ~irq_mask_pkg::VALID_BITS) == 32'h0000_0000)
        else $error("Reserved mask bit set");

    // Low enable must hold the mask and the read data, including a pending write
    chk_freeze_hold: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        !clk_en_in |=> $stable(mask_vec) && $stable(rdata_out))
        else $error("State moved while clock enable low");

    chk_mask_readback: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        clk_en_in && rd_mask |=> rdata_out == $past(mask_vec))
        else $error("Mask readback wrong");

    // Read data stand for one cycle only, then fall back to idle
    chk_rdata_idle: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        clk_en_in && !rd_in |=> rdata_out == irq_mask_pkg::READ_IDLE)
        else $error("Read data outlived its cycle");

    chk_mask_port: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        clk_en_in |=> mask_out == $past(mask_vec))
        else $error("Mask port lags wrongly");

    chk_irq_gating: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        clk_en_in |=> irq_out == |($past(flags_in) & $past(mask_vec)))
        else $error("Interrupt not gated by mask");

    chk_pend_readback: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        clk_en_in && rd_status |=> rdata_out == $past(pend_vec))
        else $error("Pending readback wrong");

    chk_crc_walk: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        s_set_then_read(irq_mask_pkg::POS_CRC)
        |=> rdata_out[irq_mask_pkg::POS_CRC])
        else $error("CRC fault mask not seen on readback");

    chk_bit_walk: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        s_clear_then_read(irq_mask_pkg::POS_BIT)
        |=> !rdata_out[irq_mask_pkg::POS_BIT])
        else $error("Bit fault mask still seen on readback");

    chk_reset_clear: assert property (
        @(posedge core_clk_in)
        !rst_b_in |=> mask_vec == irq_mask_pkg::MASK_RESET)
        else $error("Mask not zero after reset");

    chk_reset_quiet: assert property (
        @(posedge core_clk_in)
        !rst_b_in |=> !irq_out && mask_out == irq_mask_pkg::MASK_RESET)
        else $error("Outputs not quiet after reset");
endmodule
`default_nettype wire

//--- src/irq_gate.sv
// Registered gating of status flags by mask bits onto one request line
`timescale 1ns/1ps
`default_nettype none
module irq_gate (
    input  wire logic        core_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        clk_en_in,
    input  wire logic [31:0] flags_in,
    input  wire logic [31:0] mask_in,
    output var  logic [31:0] pend_out,
    output var  logic        irq_out
);
    logic [31:0] pend_d;
    logic        irq_d;
    assign pend_d = flags_in & mask_in;
    assign irq_d  = |pend_d;
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            pend_out <= 32'h0000_0000;
            irq_out  <= 1'b0;
        end else if (clk_en_in) begin
            pend_out <= pend_d;
            irq_out  <= irq_d;
        end
    end
endmodule
`default_nettype wire

//--- src/irq_mask_pkg.sv
// Register map, field positions and reset values of the interrupt mask block
package irq_mask_pkg;
    localparam int unsigned ADDR_W      = 12;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned NUM_MSGBOX  = 8;
    localparam logic [11:0] OFS_ENABLE  = 12'h004;
    localparam logic [11:0] OFS_DISABLE = 12'h008;
    localparam logic [11:0] OFS_MASK    = 12'h00C;
    localparam logic [11:0] OFS_STATUS  = 12'h010;
    localparam int unsigned POS_MSGBOX  = 0;
    localparam int unsigned POS_ACTIVE  = 16;
    localparam int unsigned POS_WARN    = 17;
    localparam int unsigned POS_PASSIVE = 18;
    localparam int unsigned POS_BUSOFF  = 19;
    localparam int unsigned POS_SLEEP   = 20;
    localparam int unsigned POS_WAKEUP  = 21;
    localparam int unsigned POS_TIMER_OVF = 22;
    localparam int unsigned POS_TSTAMP  = 23;
    localparam int unsigned POS_CRC     = 24;
    localparam int unsigned POS_STUFF   = 25;
    localparam int unsigned POS_ACK     = 26;
    localparam int unsigned POS_FORM    = 27;
    localparam int unsigned POS_BIT     = 28;
    localparam logic [31:0] VALID_BITS  = 32'h1FFF_00FF;
    localparam logic [31:0] MASK_RESET  = 32'h0000_0000;
    localparam logic [31:0] READ_IDLE   = 32'h0000_0000;
endpackage

//--- src/mask_bit_cell.sv
// One mask bit: set by enable write, cleared by disable write
`timescale 1ns/1ps
`default_nettype none
module mask_bit_cell (
    input  wire logic core_clk_in,
    input  wire logic rst_b_in,
    input  wire logic clk_en_in,
    input  wire logic set_in,
    input  wire logic clr_in,
    output var  logic mask_out
);
    logic mask_q;
    logic mask_d;
    // Enable and disable never meet: different addresses, one strobe
    assign mask_d = set_in ? 1'b1 : (clr_in ? 1'b0 : mask_q);
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            mask_q <= 1'b0;
        end else if (clk_en_in) begin
            mask_q <= mask_d;
        end
    end
    assign mask_out = mask_q;
endmodule
`default_nettype wire
